// File: drive_status_pkg.sv
package drive_status_pkg;

    // bus and register widths
    localparam int unsigned  DATA_W         = 32;
    localparam int unsigned  ADDR_W         = 8;
    localparam int unsigned  WORD_W         = 16;
    localparam int unsigned  CODE_W         = 16;
    localparam int unsigned  CNT_W          = 8;
    localparam int unsigned  IRQ_W          = 4;

    // register byte offsets
    localparam logic [7:0]   OFS_CTRL       = 8'h00;
    localparam logic [7:0]   OFS_STATUS     = 8'h04;
    localparam logic [7:0]   OFS_FAULT_CODE = 8'h08;
    localparam logic [7:0]   OFS_ALARM_CODE = 8'h0C;
    localparam logic [7:0]   OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0]   OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0]   OFS_FAULT_CNT  = 8'h18;

    // control word bits
    localparam int unsigned  CW_ON          = 0;
    localparam int unsigned  CW_NO_COAST    = 1;
    localparam int unsigned  CW_NO_QSTOP    = 2;
    localparam int unsigned  CW_ENABLE_OP   = 3;
    localparam int unsigned  CW_FAULT_ACK   = 7;

    // status word bits
    localparam int unsigned  SW_READY_ON    = 0;
    localparam int unsigned  SW_READY_RUN   = 1;
    localparam int unsigned  SW_OP_EN       = 2;
    localparam int unsigned  SW_FAULT       = 3;
    localparam int unsigned  SW_NO_COAST    = 4;
    localparam int unsigned  SW_NO_QSTOP    = 5;
    localparam int unsigned  SW_INHIBIT     = 6;
    localparam int unsigned  SW_ALARM       = 7;

    // interrupt status bits
    localparam int unsigned  IRQ_FAULT      = 0;
    localparam int unsigned  IRQ_ALARM_ON   = 1;
    localparam int unsigned  IRQ_ALARM_OFF  = 2;
    localparam int unsigned  IRQ_INHIBIT    = 3;

    // reset values
    localparam logic [WORD_W-1:0] CTRL_RST  = 16'h0000;
    localparam logic [IRQ_W-1:0]  MASK_RST  = 4'h0;

    // bus encodings
    localparam logic [1:0]   HTRANS_NONSEQ  = 2'b10;
    localparam logic         HRESP_OKAY     = 1'b0;

    typedef enum logic [2:0] {
        ST_INHIBIT     = 3'b000,
        ST_READY       = 3'b001,
        ST_SWITCHED_ON = 3'b010,
        ST_ENABLED     = 3'b011,
        ST_FAULT       = 3'b100
    } drive_state_t;

    typedef struct packed {
        logic on;
        logic no_coast;
        logic no_qstop;
        logic enable_op;
        logic fault_ack;
    } ctrl_cmd_t;

endpackage

// File: drive_state_seq.sv
`timescale 1ns/1ps
module drive_state_seq (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    // commands and causes
    input  wire drive_status_pkg::ctrl_cmd_t cmd,
    input  wire logic                        fault_cause,
    input  wire logic                        ack_pulse,
    // state
    output drive_status_pkg::drive_state_t   state_r,
    output drive_status_pkg::drive_state_t   state_nxt
);
    import drive_status_pkg::*;

    // next state; a live fault overrides every stop command
    always_comb begin
        state_nxt = state_r;
        if (state_r != ST_FAULT && fault_cause) begin
            state_nxt = ST_FAULT;
        end else if (state_r != ST_FAULT && (!cmd.no_coast || !cmd.no_qstop)) begin
            state_nxt = ST_INHIBIT;
        end else begin
            case (state_r)
                ST_INHIBIT: begin
                    if (!cmd.on) begin
                        state_nxt = ST_READY;
                    end
                end
                ST_READY: begin
                    if (cmd.on) begin
                        state_nxt = ST_SWITCHED_ON;
                    end
                end
                ST_SWITCHED_ON: begin
                    if (!cmd.on) begin
                        state_nxt = ST_READY;
                    end else if (cmd.enable_op) begin
                        state_nxt = ST_ENABLED;
                    end
                end
                ST_ENABLED: begin
                    if (!cmd.on) begin
                        state_nxt = ST_READY;
                    end else if (!cmd.enable_op) begin
                        state_nxt = ST_SWITCHED_ON;
                    end
                end
                ST_FAULT: begin
                    // ack with cause still present is ignored
                    if (ack_pulse && !fault_cause) begin
                        state_nxt = ST_INHIBIT;
                    end
                end
                default: begin
                    state_nxt = ST_INHIBIT;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_INHIBIT;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule

// File: fault_code_log.sv
`timescale 1ns/1ps
module fault_code_log #(
    parameter int unsigned CODE_W = 16,
    parameter int unsigned CNT_W  = 8
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // capture
    input  wire logic              capture,
    input  wire logic [CODE_W-1:0] code_in,
    // held values
    output logic      [CODE_W-1:0] code_r,
    output logic      [CNT_W-1:0]  count_r
);

    // latest code kept after ack so software can still read it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            code_r <= '0;
        end else if (capture) begin
            code_r <= code_in;
        end
    end

    // fault event counter, saturates instead of wrapping
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (capture && count_r != {CNT_W{1'b1}}) begin
            count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// File: drive_status_word_bits.sv
`timescale 1ns/1ps
module drive_status_word_bits (
    // clock and reset
    input  wire logic                                    mclk,
    input  wire logic                                    reset_n,
    // ahb-lite slave
    input  wire logic                                    hsel,
    input  wire logic [drive_status_pkg::ADDR_W-1:0]     haddr,
    input  wire logic [1:0]                              htrans,
    input  wire logic                                    hwrite,
    input  wire logic [2:0]                              hsize,
    input  wire logic [drive_status_pkg::DATA_W-1:0]     hwdata,
    input  wire logic                                    hready,
    output logic                                         hreadyout,
    output logic      [drive_status_pkg::DATA_W-1:0]     hrdata,
    output logic                                         hresp,
    // drive conditions
    input  wire logic                                    fault_cause,
    input  wire logic [drive_status_pkg::CODE_W-1:0]     fault_code,
    input  wire logic                                    alarm_cause,
    input  wire logic [drive_status_pkg::CODE_W-1:0]     alarm_code,
    // drive outputs
    output logic      [drive_status_pkg::WORD_W-1:0]     status_word,
    output logic                                         drive_enable,
    output logic                                         irq
);
    import drive_status_pkg::*;

    // bus phase tracking
    logic                 wr_pend_r;
    logic                 rd_pend_r;
    logic [ADDR_W-1:0]    addr_r;
    logic                 addr_take;

    // registers
    logic [WORD_W-1:0]    ctrl_r;
    logic [IRQ_W-1:0]     irq_stat_r;
    logic [IRQ_W-1:0]     irq_stat_nxt;
    logic [IRQ_W-1:0]     irq_mask_r;
    logic [CODE_W-1:0]    alarm_code_r;
    logic                 alarm_r;
    logic                 ack_pulse_r;
    logic [WORD_W-1:0]    status_nxt;

    // sub-block signals
    ctrl_cmd_t            cmd;
    drive_state_t         state_r;
    drive_state_t         state_nxt;
    logic [CODE_W-1:0]    fault_code_r;
    logic [CNT_W-1:0]     fault_cnt_r;
    logic                 fault_entry;
    logic [IRQ_W-1:0]     events;

    // write strobe for one register in the current data phase
    function automatic logic wr_hit(input logic pend, input logic [ADDR_W-1:0] a,
                                    input logic [7:0] ofs);
        wr_hit = pend && (a == ofs);
    endfunction

    // address phase accepted only while the bus is ready
    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);

    // pending phase flags; reads get one wait state so writes land first
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= '0;
        end else begin
            wr_pend_r <= addr_take && hwrite;
            rd_pend_r <= addr_take && !hwrite;
            if (addr_take) begin
                addr_r <= {haddr[ADDR_W-1:2], 2'b00};
            end
        end
    end

    // hready low only during the first cycle of a read data phase
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(addr_take && !hwrite);
        end
    end

    // error responses never used
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    // read mux, sampled at the end of the wait state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= '0;
        end else if (rd_pend_r) begin
            case (addr_r)
                OFS_CTRL:       hrdata <= {{(DATA_W-WORD_W){1'b0}}, ctrl_r};
                OFS_STATUS:     hrdata <= {{(DATA_W-WORD_W){1'b0}}, status_word};
                OFS_FAULT_CODE: hrdata <= {{(DATA_W-CODE_W){1'b0}}, fault_code_r};
                OFS_ALARM_CODE: hrdata <= {{(DATA_W-CODE_W){1'b0}}, alarm_code_r};
                OFS_IRQ_STAT:   hrdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
                OFS_IRQ_MASK:   hrdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
                OFS_FAULT_CNT:  hrdata <= {{(DATA_W-CNT_W){1'b0}}, fault_cnt_r};
                default:        hrdata <= '0;
            endcase
        end
    end

    // control word written by the master
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_hit(wr_pend_r, addr_r, OFS_CTRL)) begin
            ctrl_r <= hwdata[WORD_W-1:0];
        end
    end

    // acknowledge acts on a 0 to 1 write of the ack bit only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_pulse_r <= 1'b0;
        end else begin
            ack_pulse_r <= wr_hit(wr_pend_r, addr_r, OFS_CTRL)
                           && hwdata[CW_FAULT_ACK] && !ctrl_r[CW_FAULT_ACK];
        end
    end

    // decoded commands, one process so the struct has a single driver
    always_comb begin
        cmd.on        = ctrl_r[CW_ON];
        cmd.no_coast  = ctrl_r[CW_NO_COAST];
        cmd.no_qstop  = ctrl_r[CW_NO_QSTOP];
        cmd.enable_op = ctrl_r[CW_ENABLE_OP];
        cmd.fault_ack = ctrl_r[CW_FAULT_ACK];
    end

    // power state sequencer
    drive_state_seq u_seq (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .cmd         (cmd),
        .fault_cause (fault_cause),
        .ack_pulse   (ack_pulse_r),
        .state_r     (state_r),
        .state_nxt   (state_nxt)
    );

    assign fault_entry = (state_nxt == ST_FAULT) && (state_r != ST_FAULT);

    // fault code capture at fault entry
    fault_code_log #(
        .CODE_W (CODE_W),
        .CNT_W  (CNT_W)
    ) u_flog (
        .mclk    (mclk),
        .reset_n (reset_n),
        .capture (fault_entry),
        .code_in (fault_code),
        .code_r  (fault_code_r),
        .count_r (fault_cnt_r)
    );

    // alarm tracker; no acknowledge, follows the cause directly
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_cause;
        end
    end

    // alarm detail kept after the alarm clears for diagnosis
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_code_r <= '0;
        end else if (alarm_cause) begin
            alarm_code_r <= alarm_code;
        end
    end

    // status word built from next-state values so no bit lags another
    always_comb begin
        status_nxt               = '0;
        status_nxt[SW_READY_ON]  = (state_nxt == ST_READY) || (state_nxt == ST_SWITCHED_ON)
                                   || (state_nxt == ST_ENABLED);
        status_nxt[SW_READY_RUN] = (state_nxt == ST_SWITCHED_ON) || (state_nxt == ST_ENABLED);
        status_nxt[SW_OP_EN]     = (state_nxt == ST_ENABLED);
        status_nxt[SW_FAULT]     = (state_nxt == ST_FAULT);
        status_nxt[SW_NO_COAST]  = cmd.no_coast;
        status_nxt[SW_NO_QSTOP]  = cmd.no_qstop;
        status_nxt[SW_INHIBIT]   = (state_nxt == ST_INHIBIT);
        status_nxt[SW_ALARM]     = alarm_cause;
    end

    // single register load of the whole word
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_word <= '0;
        end else begin
            status_word <= status_nxt;
        end
    end

    // power stage enable, alarm does not remove it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            drive_enable <= 1'b0;
        end else begin
            drive_enable <= status_nxt[SW_OP_EN];
        end
    end

    // interrupt events
    always_comb begin
        events                = '0;
        events[IRQ_FAULT]     = fault_entry;
        events[IRQ_ALARM_ON]  = alarm_cause && !alarm_r;
        events[IRQ_ALARM_OFF] = !alarm_cause && alarm_r;
        events[IRQ_INHIBIT]   = (state_nxt == ST_INHIBIT) && (state_r != ST_INHIBIT);
    end

    // sticky status, write one to clear; a new event beats the clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_hit(wr_pend_r, addr_r, OFS_IRQ_STAT)) begin
            irq_stat_nxt = irq_stat_r & ~hwdata[IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // interrupt mask
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_r <= MASK_RST;
        end else if (wr_hit(wr_pend_r, addr_r, OFS_IRQ_MASK)) begin
            irq_mask_r <= hwdata[IRQ_W-1:0];
        end
    end

    // level interrupt, registered to keep the output glitch free
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

endmodule

// File: drive_status_checker.sv
`timescale 1ns/1ps
module drive_status_checker (
    // clock and reset
    input wire logic                                mclk,
    input wire logic                                reset_n,
    // bus side
    input wire logic                                hsel,
    input wire logic [drive_status_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0]                          htrans,
    input wire logic                                hwrite,
    input wire logic [drive_status_pkg::DATA_W-1:0] hwdata,
    input wire logic                                hready,
    input wire logic                                hreadyout,
    // drive side
    input wire logic                                fault_cause,
    input wire logic                                alarm_cause,
    input wire logic [drive_status_pkg::WORD_W-1:0] status_word,
    input wire logic                                drive_enable
);
    import drive_status_pkg::*;

    logic              live_r;
    logic              ctrl_wr_r;
    logic [WORD_W-1:0] ctrl_r;

    // live_r masks the first edge, where the word still holds its reset value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            live_r <= 1'b0;
        end else begin
            live_r <= 1'b1;
        end
    end

    // shadow of the control word, taken from the bus data phase
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_wr_r <= 1'b0;
            ctrl_r    <= CTRL_RST;
        end else if (hready) begin
            ctrl_wr_r <= hsel && htrans[1] && hwrite && haddr[7:2] == OFS_CTRL[7:2];
            if (ctrl_wr_r) ctrl_r <= hwdata[WORD_W-1:0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    en_mirror_a: assert property (drive_enable == status_word[SW_OP_EN])
        else $error("drive enable differs from op enabled bit");
    alarm_lag_a: assert property (live_r |-> status_word[SW_ALARM] == $past(alarm_cause))
        else $error("alarm bit does not follow alarm cause");
    fault_enter_a: assert property (live_r && fault_cause |=> status_word[SW_FAULT])
        else $error("fault cause did not set fault bit");
    fault_idle_a: assert property (status_word[SW_FAULT] |-> !status_word[SW_OP_EN] && !drive_enable)
        else $error("faulted drive still operational");
    coast_follow_a: assert property (live_r |-> status_word[SW_NO_COAST] == $past(ctrl_r[CW_NO_COAST]))
        else $error("coast stop bit does not follow control");
    qstop_follow_a: assert property (live_r |-> status_word[SW_NO_QSTOP] == $past(ctrl_r[CW_NO_QSTOP]))
        else $error("quick stop bit does not follow control");
    stop_inhibit_a: assert property (live_r && !status_word[SW_FAULT]
        && !(status_word[SW_NO_COAST] && status_word[SW_NO_QSTOP]) |-> status_word[SW_INHIBIT])
        else $error("stop active without inhibit");
    op_clear_a: assert property (status_word[SW_OP_EN] |-> !status_word[SW_INHIBIT])
        else $error("operation enabled during inhibit");
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");
    fault_leave_a: assert property ($fell(status_word[SW_FAULT])
        |-> !$past(fault_cause) && status_word[SW_INHIBIT])
        else $error("fault left without inhibit or with cause");
endmodule

bind drive_status_word_bits drive_status_checker chk (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .fault_cause(fault_cause), .alarm_cause(alarm_cause), .status_word(status_word),
    .drive_enable(drive_enable)
);

// File: drive_bus_master.sv
`timescale 1ns/1ps
module drive_bus_master (
    // clock and bus return
    input  wire logic                                mclk,
    input  wire logic                                hready,
    input  wire logic [drive_status_pkg::DATA_W-1:0] hrdata,
    // bus request
    output logic                                     hsel,
    output logic      [drive_status_pkg::ADDR_W-1:0] haddr,
    output logic      [1:0]                          htrans,
    output logic                                     hwrite,
    output logic      [2:0]                          hsize,
    output logic      [drive_status_pkg::DATA_W-1:0] hwdata
);
    import drive_status_pkg::*;

    // bus idle until a transfer is asked for
    initial begin
        hsel   = 1'b0;
        haddr  = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // one word transfer; no wait count assumed, the bench timeout ends a hang
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : ~hwdata;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~hwdata;  // stale write data must not look valid
    endtask
endmodule

// File: test_drive_status_word_bits.sv
`timescale 1ns/1ps
module test_drive_status_word_bits;
    import drive_status_pkg::*;

    logic        mclk;
    logic        reset_n;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        fault_cause;
    logic [15:0] fault_code;
    logic        alarm_cause;
    logic [15:0] alarm_code;
    logic [15:0] status_word;
    logic        drive_enable;
    logic        irq;
    int          mismatches;
    int          checks_done;

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    assign hready = hreadyout;  // one slave, so its ready is the bus ready

    drive_bus_master bus (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    drive_status_word_bits DUT (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fault_cause(fault_cause),
        .fault_code(fault_code), .alarm_cause(alarm_cause), .alarm_code(alarm_code),
        .status_word(status_word), .drive_enable(drive_enable), .irq(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus.xfer(a, 1'b1, d, v);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] v;
        bus.xfer(a, 1'b0, 32'h0, v);
        check(n, v, e);
        check("response", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    // let the word settle, then look between edges
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // bits 7 down to 2 of the status word for a drive phase
    function automatic logic [5:0] exp_hi(input drive_state_t st, input logic [15:0] c, input logic al);
        exp_hi = {al, st == ST_INHIBIT, c[CW_NO_QSTOP], c[CW_NO_COAST], st == ST_FAULT, st == ST_ENABLED};
    endfunction

    task automatic phase(input drive_state_t st, input logic [15:0] c, input logic al);
        check("status word", {16'h0, status_word}, {24'h0, exp_hi(st, c, al),
            st == ST_SWITCHED_ON || st == ST_ENABLED, st == ST_READY || st == ST_SWITCHED_ON || st == ST_ENABLED});
        check("drive enable", {31'h0, drive_enable}, {31'h0, st == ST_ENABLED});
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        finish_test();
    end

    initial begin
        logic [15:0] c;
        logic        al;
        logic [15:0] code;
        int unsigned seed;
        seed = 32'h44FB;
        void'($urandom(seed));
        mismatches  = 0;
        checks_done = 0;
        reset_n     = 1'b0;
        fault_cause = 1'b0;
        alarm_cause = 1'b0;
        fault_code  = 16'h0000;
        alarm_code  = 16'h0000;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rd_check(OFS_STATUS, 32'h0000_0040, "status after reset");
        rd_check(OFS_CTRL, 32'h0, "control reset");
        rd_check(OFS_IRQ_MASK, 32'h0, "mask reset");
        rd_check(8'h1C, 32'h0, "unmapped read");
        wr(OFS_CTRL, 32'h6);
        settle(2);
        phase(ST_READY, 16'h6, 1'b0);
        wr(OFS_CTRL, 32'hF);
        settle(3);
        phase(ST_ENABLED, 16'hF, 1'b0);
        // each stop drops to inhibit; only off then on re-closes
        for (int i = 0; i < 2; i++) begin
            c = i ? 16'h000B : 16'h000D;
            wr(OFS_CTRL, {16'h0, c});
            settle(2);
            phase(ST_INHIBIT, c, 1'b0);
            wr(OFS_CTRL, 32'hF);
            settle(3);
            phase(ST_INHIBIT, 16'hF, 1'b0);
            wr(OFS_CTRL, 32'hE);
            settle(2);
            phase(ST_READY, 16'hE, 1'b0);
            wr(OFS_CTRL, 32'hF);
            settle(3);
            phase(ST_ENABLED, 16'hF, 1'b0);
        end
        // random alarms come and go while the drive keeps running
        for (int i = 0; i < 8; i++) begin
            al   = (i == 0) | 1'($urandom);
            code = 16'($urandom);
            @(posedge mclk);
            alarm_cause <= al;
            alarm_code  <= code;
            settle(2);
            phase(ST_ENABLED, 16'hF, al);
            check("irq masked", {31'h0, irq}, 32'h0);
            if (al) rd_check(OFS_ALARM_CODE, {16'h0, code}, "alarm code");
        end
        // alarm edges latch as events; only unmasked ones reach irq
        @(posedge mclk);
        alarm_cause <= 1'b0;
        settle(1);
        wr(OFS_IRQ_STAT, 32'hF);
        wr(OFS_IRQ_MASK, 32'h2);
        @(posedge mclk);
        alarm_cause <= 1'b1;
        settle(3);
        check("irq on alarm", {31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h2);
        settle(2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        @(posedge mclk);
        alarm_cause <= 1'b0;
        settle(3);
        rd_check(OFS_IRQ_STAT, 32'h4, "alarm fall event");
        check("irq fall masked", {31'h0, irq}, 32'h0);
        // a fault stays latched until acknowledged with its cause gone
        code = 16'($urandom);
        @(posedge mclk);
        fault_cause <= 1'b1;
        fault_code  <= code;
        settle(2);
        phase(ST_FAULT, 16'hF, 1'b0);
        rd_check(OFS_FAULT_CODE, {16'h0, code}, "fault code");
        rd_check(OFS_FAULT_CNT, 32'h1, "fault count");
        wr(OFS_CTRL, 32'h8F);
        settle(3);
        phase(ST_FAULT, 16'h8F, 1'b0);
        wr(OFS_CTRL, 32'hF);
        @(posedge mclk);
        fault_cause <= 1'b0;
        settle(3);
        phase(ST_FAULT, 16'hF, 1'b0);
        wr(OFS_CTRL, 32'h8F);
        settle(3);
        phase(ST_INHIBIT, 16'h8F, 1'b0);
        wr(OFS_CTRL, 32'h8E);
        wr(OFS_CTRL, 32'h8F);
        settle(3);
        phase(ST_ENABLED, 16'h8F, 1'b0);
        rd_check(OFS_IRQ_STAT, 32'hD, "fault and inhibit events");
        finish_test();
    end
endmodule
